// ===== src/phl_heater_loop.v
// Heater PID loop: APB register file, per-sample PID arithmetic with a
// shared sequential divider, output clamp and anti-windup.
// Assumes the feedback sample strobe comes from logic on pclk and that
// the heater stage accepts a new command on any cycle.
`timescale 1ns/100ps
`include "phl_defs.vh"

module phl_heater_loop (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        fb_valid,
  input  wire [15:0] fb_data,
  output wire [15:0] heater_cmd,
  output wire        heater_upd
);

  // Sequencer: idle, then load and divide for the integral term, load
  // and divide for the derivative term, then one cycle to sum and clamp.
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_LOADI = 3'h1;
  localparam [2:0] ST_IDIV  = 3'h2;
  localparam [2:0] ST_LOADD = 3'h3;
  localparam [2:0] ST_DDIV  = 3'h4;
  localparam [2:0] ST_SUM   = 3'h5;

  // Software settings. Reset leaves the block in open loop with every
  // setting at zero, so the heater command starts at zero.
  reg               closed_q;
  reg        [15:0] setpt_q;
  reg        [15:0] pgain_q;
  reg        [15:0] irate_q;
  reg        [7:0]  drate_q;
  reg        [15:0] manual_q;
  reg        [31:0] prdata_q;
  reg               pready_q;
  reg               pslverr_q;

  // Loop state. The 40-bit accumulator holds about 128 full-scale
  // error-times-rate products before it wraps; the windup guard acts only
  // while the output is clamped, so it is no general overflow guard.
  reg        [2:0]  st_q;
  reg signed [16:0] err_q;
  reg signed [16:0] errp_q;
  reg signed [17:0] de_q;
  reg               prev_ok_q;
  reg signed [39:0] acc_q;
  reg signed [39:0] accp_q;
  reg signed [47:0] int_q;
  reg signed [47:0] der_q;
  reg        [47:0] dnum_q;
  reg        [47:0] dden_q;
  reg        [48:0] drem_q;
  reg        [5:0]  dcnt_q;
  reg               dneg_q;
  reg        [15:0] fdbk_q;
  reg        [15:0] heater_q;
  reg               upd_q;
  reg               sat_hi_q;
  reg               sat_lo_q;
  reg               ovr_q;

  // True only for mapped, word-aligned offsets; others answer with error.
  function phl_hit;
    input [7:0] a;
    begin
      case (a)
        `PHL_A_CTRL, `PHL_A_SETPT, `PHL_A_PGAIN, `PHL_A_IRATE,
        `PHL_A_DRATE, `PHL_A_MANUAL, `PHL_A_STATUS, `PHL_A_HEATER,
        `PHL_A_ERROR, `PHL_A_FDBK: phl_hit = 1'b1;
        default: phl_hit = 1'b0;
      endcase
    end
  endfunction

  // Magnitude of a two's-complement value; the divider works unsigned.
  function [47:0] phl_mag;
    input signed [47:0] v;
    begin
      phl_mag = v[47] ? (~v + 48'h1) : v;
    end
  endfunction

  // Limits a signed loop result to the span from zero to full scale.
  function [15:0] phl_clamp;
    input signed [66:0] v;
    begin
      if (v[66]) begin
        phl_clamp = 16'h0000;
      end else if (v > $signed({51'h0, `PHL_OUT_FULL})) begin
        phl_clamp = `PHL_OUT_FULL;
      end else begin
        phl_clamp = v[15:0];
      end
    end
  endfunction

  // APB: one wait state, so every answer comes from a flop.
  wire done_w  = psel & penable & pready_q;
  wire wr_w    = done_w & pwrite & phl_hit(paddr);
  wire setup_w = psel & penable & ~pready_q;
  wire clr_ovr_w = wr_w & (paddr == `PHL_A_STATUS) &
                   pwdata[`PHL_STAT_OVR];

  wire busy_w   = (st_q != ST_IDLE);
  // A zero gain in closed mode keeps the loop parked.
  wire gfault_w = closed_q & (pgain_q == 16'h0000);

  // The error is formed straight from fb_data so it is ready on the
  // strobe edge; the sample need not stand after fb_valid.
  wire signed [16:0] err_w = {1'b0, setpt_q} - {1'b0, fb_data};
  // First sample after entering closed mode has no previous error.
  wire signed [17:0] de_w = prev_ok_q ?
    ({err_w[16], err_w} - {errp_q[16], errp_q}) : 18'sh00000;
  wire signed [39:0] eprod_w = err_w * $signed({1'b0, irate_q});
  // A zero integral rate clears the sum to zero, so the integral term restarts from zero.
  wire signed [39:0] accn_w = (irate_q == 16'h0000) ? 40'sh0 :
                              acc_q + eprod_w;
  wire signed [47:0] inum_w = acc_q * $signed({1'b0, `PHL_TS_MS});
  wire signed [47:0] dnum_w = de_q * $signed({1'b0, drate_q}) *
                              $signed({1'b0, `PHL_D_SCALE});
  wire        [31:0] dprod_w = irate_q * `PHL_TS_MS;

  // Shared restoring divider: shift in the next dividend bit and
  // subtract the divisor whenever it fits.
  wire [48:0] dsh_w  = {drem_q[47:0], dnum_q[47]};
  wire        dge_w  = (dsh_w >= {1'b0, dden_q});
  wire [48:0] dsub_w = dsh_w - {1'b0, dden_q};
  wire [47:0] dq_w   = dneg_q ? (~dnum_q + 48'h1) : dnum_q;

  // The gain carries four fraction bits. The arithmetic shift floors, so a
  // negative loop term can sit one step below the exact value; the clamp
  // to zero hides that at the bottom of the range.
  wire signed [49:0] sum_w  = err_q + int_q + der_q;
  wire signed [66:0] prod_w = $signed({1'b0, pgain_q}) * sum_w;
  wire signed [66:0] loop_w = prod_w >>> `PHL_P_SHIFT;
  wire signed [66:0] tot_w  = loop_w + $signed({1'b0, manual_q});
  wire hi_w = (tot_w > $signed({51'h0, `PHL_OUT_FULL}));
  wire lo_w = tot_w[66];

  // Outputs come straight from flops; the heater stage sees no glitch.
  assign prdata     = prdata_q;
  assign pready     = pready_q;
  assign pslverr    = pslverr_q;
  assign heater_cmd = heater_q;
  assign heater_upd = upd_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end else begin
      pready_q  <= setup_w;
      pslverr_q <= setup_w & ~phl_hit(paddr);
      prdata_q  <= 32'h00000000;
      if (setup_w && !pwrite) begin
        case (paddr)
          `PHL_A_CTRL:   prdata_q <= {31'h0, closed_q};
          `PHL_A_SETPT:  prdata_q <= {16'h0, setpt_q};
          `PHL_A_PGAIN:  prdata_q <= {16'h0, pgain_q};
          `PHL_A_IRATE:  prdata_q <= {16'h0, irate_q};
          `PHL_A_DRATE:  prdata_q <= {24'h0, drate_q};
          `PHL_A_MANUAL: prdata_q <= {16'h0, manual_q};
          // Busy and gain fault are live; the other bits are registered.
          `PHL_A_STATUS: prdata_q <= {26'h0, ovr_q, gfault_w, sat_lo_q,
                                      sat_hi_q, closed_q, busy_w};
          `PHL_A_HEATER: prdata_q <= {16'h0, heater_q};
          `PHL_A_ERROR:  prdata_q <= {{15{err_q[16]}}, err_q};
          `PHL_A_FDBK:   prdata_q <= {16'h0, fdbk_q};
          default:       prdata_q <= 32'h00000000;
        endcase
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      closed_q <= `PHL_RST_CTRL;
      setpt_q  <= `PHL_RST_SETPT;
      pgain_q  <= `PHL_RST_PGAIN;
      irate_q  <= `PHL_RST_IRATE;
      drate_q  <= `PHL_RST_DRATE;
      manual_q <= `PHL_RST_MANUAL;
    end else if (wr_w) begin
      // A write lands at the edge on which the access phase completes.
      case (paddr)
        `PHL_A_CTRL:  closed_q <= pwdata[`PHL_CTRL_CLOSED];
        `PHL_A_SETPT: setpt_q  <= pwdata[15:0];
        `PHL_A_PGAIN: pgain_q  <= pwdata[15:0];
        `PHL_A_IRATE: irate_q  <= pwdata[15:0];
        `PHL_A_DRATE: begin
          // Settings above the top of the range saturate there.
          if (pwdata[31:0] > {24'h0, `PHL_D_MAX}) begin
            drate_q <= `PHL_D_MAX;
          end else begin
            drate_q <= pwdata[7:0];
          end
        end
        `PHL_A_MANUAL: begin
          if (pwdata[31:0] > {16'h0, `PHL_OUT_FULL}) begin
            manual_q <= `PHL_OUT_FULL;
          end else begin
            manual_q <= pwdata[15:0];
          end
        end
        default: closed_q <= closed_q;
      endcase
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q      <= ST_IDLE;
      err_q     <= 17'sh00000;
      errp_q    <= 17'sh00000;
      de_q      <= 18'sh00000;
      prev_ok_q <= 1'b0;
      acc_q     <= 40'sh0;
      accp_q    <= 40'sh0;
      int_q     <= 48'sh0;
      der_q     <= 48'sh0;
      dnum_q    <= 48'h0;
      dden_q    <= 48'h0;
      drem_q    <= 49'h0;
      dcnt_q    <= 6'h00;
      dneg_q    <= 1'b0;
      fdbk_q    <= 16'h0000;
      heater_q  <= 16'h0000;
      upd_q     <= 1'b0;
      sat_hi_q  <= 1'b0;
      sat_lo_q  <= 1'b0;
      ovr_q     <= 1'b0;
    end else begin
      // One sample is worked through at a time and takes about a hundred
      // cycles, or about fifty with a zero integral rate, so samples must come
      // slower than that or they are dropped.
      upd_q <= 1'b0;
      // A sample that lands on a busy loop is dropped and flagged; the
      // flag set beats a software clear in the same cycle.
      if (fb_valid && busy_w) begin
        ovr_q <= 1'b1;
      end else if (clr_ovr_w) begin
        ovr_q <= 1'b0;
      end
      case (st_q)
        ST_IDLE: begin
          if (fb_valid) begin
            fdbk_q <= fb_data;
          end
          if (!closed_q) begin
            // Feedback is not used; track the manual value.
            prev_ok_q <= 1'b0;
            sat_hi_q  <= 1'b0;
            sat_lo_q  <= 1'b0;
            if (heater_q != manual_q) begin
              heater_q <= manual_q;
              upd_q    <= 1'b1;
            end
          end else if (fb_valid) begin
            // The error is kept so the next sample can take the difference.
            err_q     <= err_w;
            errp_q    <= err_w;
            de_q      <= de_w;
            prev_ok_q <= 1'b1;
            if (gfault_w) begin
              heater_q <= manual_q;
              upd_q    <= 1'b1;
              sat_hi_q <= 1'b0;
              sat_lo_q <= 1'b0;
            end else begin
              accp_q <= acc_q;
              acc_q  <= accn_w;
              st_q   <= ST_LOADI;
            end
          end
        end
        ST_LOADI: begin
          // Integral term = sum(e*I) * period / 1e6.
          dnum_q <= phl_mag(inum_w);
          dneg_q <= inum_w[47];
          dden_q <= `PHL_I_DIV;
          drem_q <= 49'h0;
          dcnt_q <= `PHL_DIV_STEPS;
          st_q   <= ST_IDIV;
        end
        ST_LOADD: begin
          // Without integral there is no derivative time base, so the
          // derivative term is off too.
          if (irate_q == 16'h0000) begin
            der_q <= 48'sh0;
            st_q  <= ST_SUM;
          end else begin
            // Derivative = de * D * 2500 / (I * period).
            dnum_q <= phl_mag(dnum_w);
            dneg_q <= dnum_w[47];
            dden_q <= {16'h0, dprod_w};
            drem_q <= 49'h0;
            dcnt_q <= `PHL_DIV_STEPS;
            st_q   <= ST_DDIV;
          end
        end
        ST_IDIV, ST_DDIV: begin
          // Restoring divide, one quotient bit per cycle; slow but it
          // costs one subtractor for both terms.
          if (dcnt_q != 6'h00) begin
            drem_q <= dge_w ? dsub_w : dsh_w;
            dnum_q <= {dnum_q[46:0], dge_w};
            dcnt_q <= dcnt_q - 6'h01;
          end else if (st_q == ST_IDIV) begin
            int_q <= dq_w;
            st_q  <= ST_LOADD;
          end else begin
            der_q <= dq_w;
            st_q  <= ST_SUM;
          end
        end
        ST_SUM: begin
          // Manual is added after the gain, so the gain does not scale it.
          heater_q <= phl_clamp(tot_w);
          upd_q    <= 1'b1;
          sat_hi_q <= hi_w;
          sat_lo_q <= lo_w;
          // Undo this sample's accumulation when it pushes further
          // into the clamp.
          if ((hi_w && !err_q[16] && (err_q != 17'sh00000)) ||
              (lo_w && err_q[16])) begin
            acc_q <= accp_q;
          end
          st_q <= ST_IDLE;
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

endmodule

// ===== src/phl_defs.vh
// Constants for the heater PID loop: register offsets, field positions,
// reset values and the fixed-point scaling of the loop arithmetic.
// Included by the loop module, the checker and the testbench; the guard keeps repeat inclusion harmless.

`ifndef PHL_DEFS_VH
`define PHL_DEFS_VH

`define PHL_A_CTRL     8'h00
`define PHL_A_SETPT    8'h04
`define PHL_A_PGAIN    8'h08
`define PHL_A_IRATE    8'h0c
`define PHL_A_DRATE    8'h10
`define PHL_A_MANUAL   8'h14
`define PHL_A_STATUS   8'h18
`define PHL_A_HEATER   8'h1c
`define PHL_A_ERROR    8'h20
`define PHL_A_FDBK     8'h24

`define PHL_CTRL_CLOSED  0
`define PHL_STAT_BUSY    0
`define PHL_STAT_CLOSED  1
`define PHL_STAT_SATHI   2
`define PHL_STAT_SATLO   3
`define PHL_STAT_GFAULT  4
`define PHL_STAT_OVR     5

`define PHL_RST_CTRL   1'h0
`define PHL_RST_SETPT  16'h0000
`define PHL_RST_PGAIN  16'h0000
`define PHL_RST_IRATE  16'h0000
`define PHL_RST_DRATE  8'h00
`define PHL_RST_MANUAL 16'h0000

// Output and manual value are in 0.01 percent steps of full scale.
`define PHL_OUT_FULL   16'h2710
`define PHL_D_MAX      8'hc8
// Sample period of the feedback reading in milliseconds.
`define PHL_TS_MS      16'h0064
// One million: integral rate per 1000 s times period in ms.
`define PHL_I_DIV      48'h0000000f4240
// 2500 = 100 percent derivative gives a quarter of 1000/I seconds, in ms.
`define PHL_D_SCALE    16'h09c4
`define PHL_P_SHIFT    4
`define PHL_DIV_STEPS  6'h30

`endif

// ===== tb/phl_heater_loop_asserts.sv
// Checker for the heater loop, bound to its ports.
// Assumes one pclk domain and the register map of phl_defs.vh.
`timescale 1ns/100ps
`include "phl_defs.vh"
module phl_heater_loop_asserts (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        fb_valid,
  input wire [15:0] fb_data,
  input wire [15:0] heater_cmd,
  input wire        heater_upd
);
  logic        closed_q;
  logic [15:0] man_exp_q;
  wire         wr_done = psel && penable && pready && pwrite && !pslverr;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      closed_q  <= 1'b0;
      man_exp_q <= 16'h0000;
    end else if (wr_done) begin
      if (paddr == `PHL_A_CTRL)
        closed_q <= pwdata[`PHL_CTRL_CLOSED];
      if (paddr == `PHL_A_MANUAL)
        man_exp_q <= (pwdata > {16'h0, `PHL_OUT_FULL}) ? `PHL_OUT_FULL
                                                       : pwdata[15:0];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_access; psel && penable && !pready; endsequence
  sequence s_man_wr; wr_done && paddr == `PHL_A_MANUAL && !closed_q;
  endsequence
  property p_ready_next; s_access |=> pready; endproperty
  property p_err_ready; pslverr |-> pready; endproperty
  property p_rdata_zero; !pready |-> prdata == 32'h0; endproperty
  property p_man_follow;
    s_man_wr |-> ##[1:2] heater_cmd == man_exp_q;
  endproperty
  // A write one cycle earlier may still be landing, so it is excluded.
  property p_open_quiet;
    !closed_q && fb_valid && !psel && !$past(psel) |=> !heater_upd;
  endproperty
  property p_closed_ans; closed_q && fb_valid |-> ##[1:110] heater_upd;
  endproperty
  property p_upd_pulse; heater_upd |=> !heater_upd; endproperty
  property p_cmd_hold;
    heater_cmd != $past(heater_cmd) |-> heater_upd;
  endproperty
  property p_cmd_range; heater_cmd <= `PHL_OUT_FULL; endproperty
  a_ready_next:
    assert property (p_ready_next) else $error("no ready after access");
  a_err_ready:
    assert property (p_err_ready) else $error("error without ready");
  a_rdata_zero:
    assert property (p_rdata_zero) else $error("read data while idle");
  a_man_follow:
    assert property (p_man_follow) else $error("command not manual");
  a_open_quiet:
    assert property (p_open_quiet) else $error("open loop used sample");
  a_closed_ans:
    assert property (p_closed_ans) else $error("no loop update");
  a_upd_pulse:
    assert property (p_upd_pulse) else $error("update pulse too long");
  a_cmd_hold:
    assert property (p_cmd_hold) else $error("command moved silently");
  a_cmd_range:
    assert property (p_cmd_range) else $error("command above full");
endmodule
bind phl_heater_loop phl_heater_loop_asserts u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .fb_valid(fb_valid),
  .fb_data(fb_data), .heater_cmd(heater_cmd), .heater_upd(heater_upd));

// ===== tb/phl_sensor_model.sv
// Feedback sensor model: delivers one reading with a one-cycle strobe.
// Assumes the caller spaces samples by waiting for each heater update.
`timescale 1ns/100ps
module phl_sensor_model (
  input  wire         pclk,
  output logic        fb_valid,
  output logic [15:0] fb_data
);
  initial begin
    fb_valid = 1'b0;
    fb_data  = 16'h0000;
  end
  task automatic send(input logic [15:0] v);
    @(posedge pclk);
    fb_valid <= 1'b1;
    fb_data  <= v;
    @(posedge pclk);
    fb_valid <= 1'b0;
    // Inverted data after the strobe catches a loop that reads too late.
    fb_data  <= ~v;
  endtask
endmodule

// ===== tb/tb_top.sv
// Testbench for the heater loop: APB master, sensor model, checks.
// Assumes phl_defs.vh is on the include path.
`timescale 1ns/100ps
`include "phl_defs.vh"
module tb_top;
  typedef struct packed {
    logic [15:0] sp, fb, pg, man, exp;
  } phl_row_t;
  logic               pclk = 1'b0;
  logic               presetn = 1'b0;
  logic               psel = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite = 1'b0;
  logic [7:0]         paddr = 8'h00;
  logic [31:0]        pwdata = 32'h0;
  logic [31:0]        rd;
  logic               err;
  logic signed [16:0] e17;
  wire  [31:0]        prdata;
  wire                pready, pslverr, fb_valid, heater_upd;
  wire  [15:0]        fb_data, heater_cmd;
  int                 failures = 0;
  int                 num_checks = 0;
  phl_row_t rows [5] = '{
    '{16'h03e8, 16'h0384, 16'h0010, 16'h0000, 16'h0064},
    '{16'h03e8, 16'h03e8, 16'h0020, 16'h0000, 16'h0000},
    '{16'h0384, 16'h03e8, 16'h0010, 16'h01f4, 16'h0190},
    '{16'h0384, 16'h03e8, 16'h0010, 16'h0000, 16'h0000},
    '{16'h4e20, 16'h0000, 16'h00a0, 16'h0000, 16'h2710}};
  logic [15:0] pid_fb [3] = '{16'h0384, 16'h03e8, 16'h03e8};
  logic [15:0] pid_exp [3] = '{16'h0065, 16'h0000, 16'h0001};
  phl_heater_loop u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fb_valid(fb_valid), .fb_data(fb_data), .heater_cmd(heater_cmd),
    .heater_upd(heater_upd));
  phl_sensor_model u_sens (.pclk(pclk), .fb_valid(fb_valid),
    .fb_data(fb_data));
  initial begin
    forever #2.5 pclk = ~pclk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    while (pready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    if (n == 20)
      failures++;
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic sample(input logic [15:0] v);
    int n = 0;
    u_sens.send(v);
    while (heater_upd !== 1'b1 && n < 200) begin
      @(posedge pclk);
      n++;
    end
    if (n == 200)
      failures++;
  endtask
  task automatic stop_test;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    stop_test;
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk("reset value", rd, 32'h0);
    end
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped err", {31'h0, err}, 32'h1);
    chk("unmapped data", rd, 32'h0);
    foreach (rows[i]) begin
      apb(1'b1, `PHL_A_SETPT, {16'h0, rows[i].sp});
      apb(1'b1, `PHL_A_PGAIN, {16'h0, rows[i].pg});
      apb(1'b1, `PHL_A_MANUAL, {16'h0, rows[i].man});
      apb(1'b1, `PHL_A_CTRL, 32'h1);
      sample(rows[i].fb);
      chk("heater", {16'h0, heater_cmd},
          {16'h0, rows[i].exp});
      e17 = {1'b0, rows[i].sp} - {1'b0, rows[i].fb};
      apb(1'b0, `PHL_A_ERROR, 32'h0);
      chk("error", rd, {{15{e17[16]}}, e17});
    end
    apb(1'b1, `PHL_A_IRATE, 32'h64);
    apb(1'b1, `PHL_A_DRATE, 32'h64);
    apb(1'b1, `PHL_A_PGAIN, 32'h10);
    apb(1'b1, `PHL_A_SETPT, 32'h3e8);
    apb(1'b1, `PHL_A_CTRL, 32'h0);
    apb(1'b1, `PHL_A_CTRL, 32'h1);
    for (int i = 0; i < 3; i++) begin
      sample(pid_fb[i]);
      chk("pid", {16'h0, heater_cmd},
          {16'h0, pid_exp[i]});
    end
    apb(1'b1, `PHL_A_DRATE, 32'hff);
    apb(1'b0, `PHL_A_DRATE, 32'h0);
    chk("d limit", rd, 32'hc8);
    apb(1'b1, `PHL_A_CTRL, 32'h0);
    apb(1'b1, `PHL_A_MANUAL, 32'h2af8);
    repeat (3) @(posedge pclk);
    chk("open cmd", {16'h0, heater_cmd}, 32'h2710);
    u_sens.send(16'h0000);
    repeat (120) @(posedge pclk);
    chk("open hold", {16'h0, heater_cmd}, 32'h2710);
    apb(1'b1, `PHL_A_MANUAL, 32'h0);
    apb(1'b1, `PHL_A_PGAIN, 32'h0);
    apb(1'b1, `PHL_A_CTRL, 32'h1);
    apb(1'b1, `PHL_A_MANUAL, 32'h12c);
    apb(1'b0, `PHL_A_STATUS, 32'h0);
    chk("gain fault", {31'h0, rd[`PHL_STAT_GFAULT]}, 32'h1);
    sample(16'h0100);
    chk("zero gain cmd", {16'h0, heater_cmd}, 32'h12c);
    // A second sample two cycles later lands on a busy loop.
    apb(1'b1, `PHL_A_PGAIN, 32'h10);
    u_sens.send(16'h0100);
    sample(16'h0100);
    chk("closed sum", {16'h0, heater_cmd}, 32'h41c);
    apb(1'b0, `PHL_A_STATUS, 32'h0);
    chk("overrun", {31'h0, rd[`PHL_STAT_OVR]}, 32'h1);
    apb(1'b1, `PHL_A_STATUS, 32'h20);
    apb(1'b0, `PHL_A_STATUS, 32'h0);
    chk("overrun clr", {31'h0, rd[`PHL_STAT_OVR]}, 32'h0);
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    chk("reset cmd", {16'h0, heater_cmd}, 32'h0);
    presetn <= 1'b1;
    apb(1'b0, `PHL_A_CTRL, 32'h0);
    chk("reset ctrl", rd, 32'h0);
    stop_test;
  end
endmodule
